// file: inc/adc_conv_pkg.sv
// shared constants and types of the converter sequencer and serial readout
package adc_conv_pkg;

  // result word
  localparam int          RES_BITS    = 16;
  localparam logic [15:0] MSB_TRIAL   = 16'h8000;
  localparam logic [15:0] CODE_FLIP   = 16'h8000;
  localparam logic [15:0] RESULT_RST  = 16'h0000;
  localparam logic [15:0] CODE_POS_FS = 16'h7FFF;
  localparam logic [15:0] CODE_NEG_FS = 16'h8000;

  // timing on the system clock
  localparam int SYS_PERIOD_NS = 10;
  localparam int SETTLE_NS     = 30;
  localparam int SETTLE_CYCLES =
    (SETTLE_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int FRAME_RATE_KSPS = 100;
  localparam int FRAME_NS        = 1000000 / FRAME_RATE_KSPS;
  localparam int FRAME_CYCLES    =
    (FRAME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int SYNC_DEPTH      = 2;

  // serial side
  localparam logic [2:0] ENABLE_EDGE = 3'h5;
  localparam logic [2:0] EDGE_MAX    = 3'h7;

  typedef enum logic [2:0] {
    ST_TRACK,
    ST_OPEN_SW,
    ST_HOLD,
    ST_SETTLE,
    ST_DECIDE,
    ST_FINISH
  } conv_state_t;

  // switch settings of the two sampling arrays
  typedef struct packed {
    logic        pos_closed;
    logic        neg_closed;
    logic        on_inputs;
    logic [15:0] trial;
  } array_ctrl_t;

  localparam array_ctrl_t ARRAY_TRACK = '{
    pos_closed: 1'b1,
    neg_closed: 1'b1,
    on_inputs:  1'b1,
    trial:      16'h0000
  };

endpackage

// file: logic/sar_adc_conv.sv
// converter sequencer and serial result readout
`timescale 1ns/100ps
`default_nettype none

// How it works
// - a falling edge of conv_sel_n samples the input and starts a conversion.
// - when a conversion ends the converter drops back to shutdown by itself.
// - the result pin is driven only while conv_sel_n is low, else released.
// - the result leaves serially in step with serial_shift_clock.
// - starts come no faster than 100 kSPS; the converter sleeps between them.
// - a frame returns the sample taken at its own select edge, no latency.
// - tracking while idle; on start open the sample switches, then the arrays.
// - sixteen binary-weighted trials resolve the word, MSB first.
// - after the last trial return to acquisition and form the output code.
// - the output code is two's complement around a midscale of zero.
// - an over-range input gives 7FFF and never wraps.
// - an under-range input gives 8000 and never wraps.
// - at the fifth shift clock falling edge the pin is enabled and low.
// - each later falling edge presents the next bit, MSB first.
module sar_adc_conv #(
  parameter int SETTLE_CYC = adc_conv_pkg::SETTLE_CYCLES,
  parameter int FRAME_CYC  = adc_conv_pkg::FRAME_CYCLES
) (
  // system clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      resetn,
  // host pins
  input  wire logic                      conv_sel_n,
  input  wire logic                      serial_shift_clock,
  output logic                           result_out,
  output logic                           result_oe_n,
  // analog front end
  input  wire logic                      comp_above,
  output adc_conv_pkg::array_ctrl_t      array_ctrl,
  output logic                           converter_awake
);
  import adc_conv_pkg::*;

  localparam int RATE_W = $clog2(FRAME_CYC + 1);
  localparam int SET_W  = $clog2(SETTLE_CYC + 1);
  localparam logic [RATE_W-1:0] RATE_DONE = RATE_W'(FRAME_CYC - 1);
  localparam logic [SET_W-1:0]  SET_LOAD  = SET_W'(SETTLE_CYC - 1);

  if (SETTLE_CYC <= SYNC_DEPTH) begin : g_settle_check
    $error("SETTLE_CYC must exceed the comparator sync depth");
  end
  if (FRAME_CYC < 2 * RES_BITS + 8) begin : g_frame_check
    $error("FRAME_CYC too short for one conversion");
  end

  function automatic logic [15:0] to_twos(input logic [15:0] offset);
    to_twos = offset ^ CODE_FLIP;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers on the system clock
  logic cs_s1_reg;
  logic cs_s2_reg;
  logic cs_s3_reg;
  logic cmp_s1_reg;
  logic cmp_s2_reg;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cs_s1_reg  <= 1'b1;
      cs_s2_reg  <= 1'b1;
      cs_s3_reg  <= 1'b1;
      cmp_s1_reg <= 1'b0;
      cmp_s2_reg <= 1'b0;
    end else begin
      cs_s1_reg  <= conv_sel_n;
      cs_s2_reg  <= cs_s1_reg;
      cs_s3_reg  <= cs_s2_reg;
      cmp_s1_reg <= comp_above;
      cmp_s2_reg <= cmp_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame rate guard
  logic [RATE_W-1:0] rate_cnt_reg;
  logic              sel_fall;
  logic              rate_ok;
  logic              start;
  conv_state_t       state_reg;

  assign sel_fall = cs_s3_reg & ~cs_s2_reg;
  assign rate_ok  = (rate_cnt_reg == RATE_DONE);
  assign start    = sel_fall & rate_ok & (state_reg == ST_TRACK);

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rate_cnt_reg <= RATE_DONE;
    end else if (start) begin
      rate_cnt_reg <= '0;
    end else if (!rate_ok) begin
      rate_cnt_reg <= rate_cnt_reg + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // successive approximation sequencer
  logic [15:0]     mask_reg;
  logic [SET_W-1:0] settle_reg;
  logic [15:0]     result_reg;
  logic            ready_reg;
  logic [15:0]     trial_next;

  always_comb begin
    trial_next = array_ctrl.trial;
    if (!cmp_s2_reg) begin
      trial_next = trial_next & ~mask_reg;
    end
    trial_next = trial_next | (mask_reg >> 1);
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_reg <= ST_TRACK;
    end else begin
      case (state_reg)
        ST_TRACK: begin
          if (start) begin
            state_reg <= ST_OPEN_SW;
          end
        end
        ST_OPEN_SW: state_reg <= ST_HOLD;
        ST_HOLD:    state_reg <= ST_SETTLE;
        ST_SETTLE: begin
          if (settle_reg == '0) begin
            state_reg <= ST_DECIDE;
          end
        end
        ST_DECIDE: begin
          if (mask_reg == 16'h0001) begin
            state_reg <= ST_FINISH;
          end else begin
            state_reg <= ST_SETTLE;
          end
        end
        ST_FINISH: state_reg <= ST_TRACK;
        default:   state_reg <= ST_TRACK;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      settle_reg <= '0;
    end else if (state_reg == ST_HOLD || state_reg == ST_DECIDE) begin
      settle_reg <= SET_LOAD;
    end else if (settle_reg != '0) begin
      settle_reg <= settle_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      mask_reg <= '0;
    end else if (state_reg == ST_HOLD) begin
      mask_reg <= MSB_TRIAL;
    end else if (state_reg == ST_DECIDE) begin
      mask_reg <= mask_reg >> 1;
    end
  end

  // switch sequence of the sampling arrays
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      array_ctrl <= ARRAY_TRACK;
    end else begin
      case (state_reg)
        ST_TRACK: begin
          if (start) begin
            array_ctrl.pos_closed <= 1'b0;
            array_ctrl.neg_closed <= 1'b0;
          end
        end
        ST_OPEN_SW: begin
          array_ctrl.on_inputs <= 1'b0;
          array_ctrl.trial     <= MSB_TRIAL;
        end
        ST_DECIDE: begin
          array_ctrl.trial <= trial_next;
        end
        ST_FINISH: begin
          array_ctrl <= ARRAY_TRACK;
        end
        default: array_ctrl <= array_ctrl;
      endcase
    end
  end

  // awake only between the start and the end of the conversion
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      converter_awake <= 1'b0;
    end else if (start) begin
      converter_awake <= 1'b1;
    end else if (state_reg == ST_FINISH) begin
      converter_awake <= 1'b0;
    end
  end

  // the array word saturates by itself, so the code clamps at both ends
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      result_reg <= RESULT_RST;
      ready_reg  <= 1'b0;
    end else if (start) begin
      ready_reg  <= 1'b0;
    end else if (state_reg == ST_FINISH) begin
      result_reg <= to_twos(array_ctrl.trial);
      ready_reg  <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial readout on the shift clock, cleared by select high
  logic       rdy_s1_reg;
  logic       rdy_s2_reg;
  logic [2:0] edge_cnt_reg;
  logic [15:0] shift_reg;

  always_ff @(negedge serial_shift_clock or posedge conv_sel_n) begin
    if (conv_sel_n) begin
      rdy_s1_reg <= 1'b0;
      rdy_s2_reg <= 1'b0;
    end else begin
      rdy_s1_reg <= ready_reg;
      rdy_s2_reg <= rdy_s1_reg;
    end
  end

  always_ff @(negedge serial_shift_clock or posedge conv_sel_n) begin
    if (conv_sel_n) begin
      edge_cnt_reg <= '0;
    end else if (edge_cnt_reg != EDGE_MAX) begin
      edge_cnt_reg <= edge_cnt_reg + 1'b1;
    end
  end

  // result word is stable once the ready level has crossed over
  always_ff @(negedge serial_shift_clock or posedge conv_sel_n) begin
    if (conv_sel_n) begin
      result_oe_n <= 1'b1;
      result_out  <= 1'b0;
      shift_reg   <= '0;
    end else if (edge_cnt_reg == ENABLE_EDGE - 3'h1) begin
      result_oe_n <= 1'b0;
      result_out  <= 1'b0;
    end else if (edge_cnt_reg == ENABLE_EDGE) begin
      result_out  <= rdy_s2_reg & result_reg[15];
      shift_reg   <= rdy_s2_reg ? {result_reg[14:0], 1'b0} : '0;
    end else if (edge_cnt_reg > ENABLE_EDGE) begin
      result_out  <= shift_reg[15];
      shift_reg   <= {shift_reg[14:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  logic [4:0] dec_cnt_reg;
  logic       all_kept_reg;
  logic       none_kept_reg;
  logic       first_dec_reg;

  always_ff @(posedge clk_sys) begin
    if (!resetn || start) begin
      dec_cnt_reg   <= '0;
      all_kept_reg  <= 1'b1;
      none_kept_reg <= 1'b1;
      first_dec_reg <= 1'b0;
    end else if (state_reg == ST_DECIDE) begin
      dec_cnt_reg   <= dec_cnt_reg + 1'b1;
      all_kept_reg  <= all_kept_reg & cmp_s2_reg;
      none_kept_reg <= none_kept_reg & ~cmp_s2_reg;
      if (mask_reg == MSB_TRIAL) begin
        first_dec_reg <= cmp_s2_reg;
      end
    end
  end

  sequence s_open_then_hold;
    (!array_ctrl.pos_closed && !array_ctrl.neg_closed
      && array_ctrl.on_inputs)
    ##1 (!array_ctrl.on_inputs && array_ctrl.trial == MSB_TRIAL);
  endsequence

  sequence s_wake_and_block;
    converter_awake && !ready_reg && !rate_ok;
  endsequence

  property p_start;
    @(posedge clk_sys) disable iff (!resetn)
      start |=> state_reg == ST_OPEN_SW ##0 s_wake_and_block;
  endproperty
  a_start: assert property (p_start)
    else $error("select fall did not start a conversion");
  property p_switch_order;
    @(posedge clk_sys) disable iff (!resetn)
      start |=> s_open_then_hold;
  endproperty
  a_switch_order: assert property (p_switch_order)
    else $error("sampling switches not released in order");
  property p_sixteen;
    @(posedge clk_sys) disable iff (!resetn)
      state_reg == ST_FINISH |-> dec_cnt_reg == 5'd16;
  endproperty
  a_sixteen: assert property (p_sixteen)
    else $error("conversion did not take sixteen decisions");
  property p_shutdown;
    @(posedge clk_sys) disable iff (!resetn)
      state_reg == ST_FINISH |=> !converter_awake && ready_reg
        && state_reg == ST_TRACK && array_ctrl == ARRAY_TRACK;
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("no shutdown after the conversion");
  property p_rate;
    @(posedge clk_sys) disable iff (!resetn)
      start |=> !start [*8];
  endproperty
  a_rate: assert property (p_rate)
    else $error("starts too close together");
  property p_sign;
    @(posedge clk_sys) disable iff (!resetn)
      state_reg == ST_FINISH |=> result_reg[15] == !first_dec_reg;
  endproperty
  a_sign: assert property (p_sign)
    else $error("sign bit does not follow the first decision");
  property p_clamp_hi;
    @(posedge clk_sys) disable iff (!resetn)
      state_reg == ST_FINISH && all_kept_reg |=> result_reg == CODE_POS_FS;
  endproperty
  a_clamp_hi: assert property (p_clamp_hi)
    else $error("over-range code is not 7FFF");
  property p_clamp_lo;
    @(posedge clk_sys) disable iff (!resetn)
      state_reg == ST_FINISH && none_kept_reg |=> result_reg == CODE_NEG_FS;
  endproperty
  a_clamp_lo: assert property (p_clamp_lo)
    else $error("under-range code is not 8000");
  property p_released;
    @(posedge clk_sys) disable iff (!resetn)
      cs_s2_reg |-> result_oe_n;
  endproperty
  a_released: assert property (p_released)
    else $error("result pin driven while select high");
  property p_enable;
    @(negedge serial_shift_clock) disable iff (conv_sel_n)
      edge_cnt_reg == ENABLE_EDGE - 3'h1 |=> !result_oe_n && !result_out;
  endproperty
  a_enable: assert property (p_enable)
    else $error("pin not enabled low at the fifth edge");
  property p_shift;
    @(negedge serial_shift_clock) disable iff (conv_sel_n)
      edge_cnt_reg > ENABLE_EDGE |=> result_out == $past(shift_reg[15]);
  endproperty
  a_shift: assert property (p_shift)
    else $error("serial bit out of order");

endmodule

`default_nettype wire

// file: tb/adc_host_model.sv
// host controller model: select, shift clock and result capture
`timescale 1ns/100ps
`default_nettype none
module adc_host_model (
  // system clock
  input  wire logic clk_sys,
  // host pins
  output logic      conv_sel_n,
  output logic      serial_shift_clock,
  input  wire logic result_line
);

  // the link side has no reset: an early rising select clears it
  initial begin
    conv_sel_n         = 1'b0;
    serial_shift_clock = 1'b0;
    #1;
    conv_sel_n         = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic sel_set(input logic level);
    @(posedge clk_sys);
    conv_sel_n <= level;
  endtask

  // shift clock runs only inside a frame and rests low between frames
  task automatic frame(output logic [15:0] word,
                       output logic [15:0] word_f, output logic lead,
                       output logic oe_early);
    word   = 16'h0000;
    word_f = 16'h0000;
    sel_set(1'b0);
    // first edges come late enough for the result to be ready
    #803;
    for (int k = 1; k <= 22; k++) begin
      serial_shift_clock = 1'b1;
      if (k == 5) oe_early = result_line;
      if (k == 6) lead = result_line;
      if (k >= 7) word = {word[14:0], result_line};
      #16;
      if (k >= 7) word_f = {word_f[14:0], result_line};
      serial_shift_clock = 1'b0;
      #16;
    end
    sel_set(1'b1);
    // idle gap lets the arrays reacquire and keeps the frame rate legal
    #1000;
  endtask

endmodule
`default_nettype wire

// file: tb/sar_adc_conversion_serial_readout_bench.sv
// testbench of the converter sequencer and serial readout
`timescale 1ns/100ps
`default_nettype none
module sar_adc_conversion_serial_readout_bench;
  import adc_conv_pkg::*;

  logic        clk_sys;
  logic        resetn;
  logic        conv_sel_n;
  logic        serial_shift_clock;
  logic        result_out;
  logic        result_oe_n;
  logic        comp_above;
  array_ctrl_t array_ctrl;
  logic        converter_awake;
  wire logic   result_line;
  int          v_in = 0;
  int          held = 32768;
  int          cyc = 0;
  int          n_fail = 0;
  int          total_checks = 0;

  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;

  // no pull on the result pin: released reads as z
  assign result_line = result_oe_n ? 1'bz : result_out;

  // front end: arrays follow the input while connected, then hold it
  always @(posedge clk_sys) begin
    if (array_ctrl.on_inputs === 1'b1) held <= v_in + 32768;
  end
  assign comp_above = held >= int'({16'h0000, array_ctrl.trial});

  sar_adc_conv #(.SETTLE_CYC(3), .FRAME_CYC(100)) u_dut (
    .clk_sys            (clk_sys),
    .resetn             (resetn),
    .conv_sel_n         (conv_sel_n),
    .serial_shift_clock (serial_shift_clock),
    .result_out         (result_out),
    .result_oe_n        (result_oe_n),
    .comp_above         (comp_above),
    .array_ctrl         (array_ctrl),
    .converter_awake    (converter_awake)
  );

  adc_host_model u_host (
    .clk_sys            (clk_sys),
    .conv_sel_n         (conv_sel_n),
    .serial_shift_clock (serial_shift_clock),
    .result_line        (result_line)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] exp_code(input int v);
    if (v > 32767) return 16'h7fff;
    if (v < -32768) return 16'h8000;
    return v[15:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // follows one conversion; the input moves once the conversion has ended
  task automatic watch_conv(input int v_late);
    int i;
    for (i = 0; i < 20 && converter_awake !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk1(converter_awake, 1'b1);
    repeat (2) @(posedge clk_sys);
    #1;
    chk1(array_ctrl.pos_closed | array_ctrl.neg_closed, 1'b0);
    chk1(array_ctrl.on_inputs, 1'b0);
    for (i = 0; i < 200 && converter_awake !== 1'b0; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk1(converter_awake, 1'b0);
    v_in = v_late;
  endtask

  task automatic do_frame(input int v, input int v_late);
    logic [15:0] word;
    logic [15:0] word_f;
    logic        lead;
    logic        early;
    v_in = v;
    fork
      u_host.frame(word, word_f, lead, early);
      watch_conv(v_late);
    join
    chk16(word, exp_code(v));
    chk16(word_f, exp_code(v));
    chk1(lead, 1'b0);
    chk1(early, 1'bz);
    chk1(result_oe_n, 1'b1);
    chk1(array_ctrl === ARRAY_TRACK, 1'b1);
  endtask

  // midscale, single steps, full scale and both clamps
  task automatic t_codes();
    int vals[8] = '{0, 1, -1, -32768, 32767, 40000, -40000, 12345};
    foreach (vals[i]) do_frame(vals[i], vals[i]);
  endtask

  // input swings after the hold; next frame must see the new value at once
  task automatic t_no_latency();
    do_frame(100, -100);
    do_frame(-100, -100);
  endtask

  // a second start inside the rate window is ignored
  task automatic t_refuse();
    int highs;
    highs = 0;
    v_in = 7;
    u_host.sel_set(1'b0);
    watch_conv(7);
    u_host.sel_set(1'b1);
    repeat (3) @(posedge clk_sys);
    u_host.sel_set(1'b0);
    repeat (20) begin
      @(posedge clk_sys);
      #1;
      if (converter_awake !== 1'b0) highs++;
    end
    chk1(highs == 0, 1'b1);
    u_host.sel_set(1'b1);
    #1000;
  endtask

  // reset in mid conversion puts the converter back to sleep and tracking
  task automatic t_mid_reset();
    v_in = 5;
    u_host.sel_set(1'b0);
    repeat (6) @(posedge clk_sys);
    #1;
    chk1(converter_awake, 1'b1);
    u_host.sel_set(1'b1);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (2) begin
      @(posedge clk_sys);
      #1;
      chk1(converter_awake, 1'b0);
      chk1(array_ctrl === ARRAY_TRACK, 1'b1);
      chk1(result_oe_n, 1'b1);
    end
    do_frame(-3, -3);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end

  initial begin
    resetn = 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    t_codes();
    t_no_latency();
    t_refuse();
    do_frame(-2, -2);
    t_mid_reset();
    results();
  end

endmodule
`default_nettype wire
